// *** rrx_pkg.sv ***
// constants shared by the rotate-right execution block
package rrx_pkg;
   // ************************************************************
   // instruction encoding
   // ************************************************************
   localparam logic [5:0] OPC_ROT_RIGHT_PLAIN = 6'h10;
   localparam int OPC_MSB = 15;
   localparam int OPC_LSB = 10;
   localparam int DEST_BIT = 9;
   localparam int ACC_BIT = 8;
   localparam int FADDR_MSB = 7;
   localparam int FADDR_LSB = 0;
   localparam logic DEST_WREG = 1'b0;
   localparam logic DEST_FILE = 1'b1;
   localparam logic ACC_SHARED = 1'b0;
   localparam logic ACC_BANKED = 1'b1;

   // ************************************************************
   // addressing
   // ************************************************************
   localparam logic [7:0] IDX_OFFSET_MAX = 8'h5f;
   localparam logic [7:0] ACC_SPLIT_NORMAL = 8'h80;
   localparam logic [7:0] ACC_SPLIT_EXT = 8'h60;
   localparam logic [3:0] ACC_HIGH_BANK = 4'hf;
   localparam logic [3:0] ACC_LOW_BANK = 4'h0;

   // ************************************************************
   // instruction cycle phases and reset values
   // ************************************************************
   localparam logic [1:0] PH_DECODE = 2'h0;
   localparam logic [1:0] PH_READ = 2'h1;
   localparam logic [1:0] PH_PROCESS = 2'h2;
   localparam logic [1:0] PH_WRITE = 2'h3;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam int CYCLES_PER_INSTR = 4;
endpackage

// *** rrx_addr_gen.sv ***
// operand address former: shared bank, banked or indexed literal offset
`timescale 1ns/100ps
module rrx_addr_gen #(
   parameter int ADDR_W = 12,
   parameter int BSR_W = 4
) (
   input wire logic [7:0] faddr, // address field of the instruction
   input wire logic acc_sel, // access select bit
   input wire logic ext_set_en, // extended instruction set enabled
   input wire logic [BSR_W-1:0] bank_select_reg, // bank select value
   input wire logic [ADDR_W-1:0] index_base, // base for literal offset
   output logic [ADDR_W-1:0] data_addr, // resulting data memory address
   output logic indexed // literal offset mode in use
);
   // elaboration check: address is bank bits above the 8-bit field
   if (ADDR_W != BSR_W + 8) begin
      $error("rrx_addr_gen: ADDR_W must equal BSR_W + 8");
   end

   function automatic logic [ADDR_W-1:0] shared_addr(
      input logic [7:0] f, input logic ext);
      logic [7:0] split;
      split = ext ? rrx_pkg::ACC_SPLIT_EXT : rrx_pkg::ACC_SPLIT_NORMAL;
      if (f < split) begin
         shared_addr = {{(BSR_W-4){1'b0}}, rrx_pkg::ACC_LOW_BANK, f};
      end else begin
         shared_addr = {{(BSR_W-4){1'b1}}, rrx_pkg::ACC_HIGH_BANK, f};
      end
   endfunction

   always_comb begin
      indexed = 1'b0;
      if (acc_sel == rrx_pkg::ACC_BANKED) begin
         data_addr = {bank_select_reg, faddr}; // RL6
      end else if (ext_set_en && faddr <= rrx_pkg::IDX_OFFSET_MAX) begin
         indexed = 1'b1; // RL7
         data_addr = index_base + {{(ADDR_W-8){1'b0}}, faddr}; // RL7
      end else begin
         data_addr = shared_addr(faddr, ext_set_en); // RL5
      end
   end
endmodule

// *** rrx_rot_exec.sv ***
// rotate-right-without-carry execution unit of an 8-bit core
//
// Operation
// RL1: decode the 16-bit rotate-right-plain encoding
// RL2: rotate operand right, bit zero into top
// RL3: destination clear: result to working register
// RL4: destination set: result back to file register
// RL5: access clear: use shared access bank
// RL6: access set: bank from bank select register
// RL7: extended set, access clear, f<=95: indexed
// RL8: update only negative and zero flags
// RL9: one word, four phases in one cycle
`timescale 1ns/100ps
module rrx_rot_exec #(
   parameter int ADDR_W = 12,
   parameter int BSR_W = 4
) (
   input wire logic ref_clk, // 125 MHz core clock
   input wire logic resetn, // async reset, active low
   input wire logic instr_valid, // instr_word holds a fetched word
   input wire logic [15:0] instr_word, // fetched program word
   input wire logic [BSR_W-1:0] bank_select_reg, // bank select value
   input wire logic ext_set_en, // extended instruction set on
   input wire logic [ADDR_W-1:0] index_base, // literal offset base
   input wire logic [7:0] mem_rdata, // data memory read data
   output logic [1:0] phase, // current instruction phase
   output logic op_hit, // rotate instruction accepted
   output logic [ADDR_W-1:0] mem_addr, // data memory address
   output logic mem_rd_en, // data memory read strobe
   output logic mem_wr_en, // data memory write strobe
   output logic [7:0] mem_wdata, // data memory write data
   output logic wreg_wr_en, // working register write strobe
   output logic [7:0] wreg_wdata, // working register write data
   output logic flag_wr_en, // negative and zero flag write strobe
   output logic flag_n, // new negative flag
   output logic flag_z, // new zero flag
   output logic idx_mode // operand used literal offset mode
);
   // elaboration check: shared bank needs at least four bank bits
   if (BSR_W < 4) begin
      $error("rrx_rot_exec: BSR_W must be at least 4");
   end

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic is_rot_right_plain(input logic [15:0] w);
      is_rot_right_plain = (w[rrx_pkg::OPC_MSB:rrx_pkg::OPC_LSB] ==
                            rrx_pkg::OPC_ROT_RIGHT_PLAIN);
   endfunction

   function automatic logic [7:0] rot_right(input logic [7:0] v);
      rot_right = {v[0], v[7:1]};
   endfunction

   // ************************************************************
   // phase sequencer
   // ************************************************************
   typedef enum logic [1:0] {
      RRX_Q1,
      RRX_Q2,
      RRX_Q3,
      RRX_Q4
   } rrx_phase_e;

   rrx_phase_e phase_q;
   rrx_phase_e phase_d;
   logic [1:0] phase_out_q;
   logic busy_q;
   logic dest_q;
   logic [7:0] result;
   logic [ADDR_W-1:0] op_addr;
   logic op_indexed;
   logic hit;

   always_comb begin
      unique case (phase_q)
         RRX_Q1: phase_d = RRX_Q2;
         RRX_Q2: phase_d = RRX_Q3;
         RRX_Q3: phase_d = RRX_Q4;
         RRX_Q4: phase_d = RRX_Q1;
      endcase
   end

   // four phases make one instruction cycle
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         phase_q <= RRX_Q1;
      end else begin
         phase_q <= phase_d; // RL9
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         phase_out_q <= rrx_pkg::PH_DECODE;
      end else begin
         unique case (phase_d)
            RRX_Q1: phase_out_q <= rrx_pkg::PH_DECODE;
            RRX_Q2: phase_out_q <= rrx_pkg::PH_READ;
            RRX_Q3: phase_out_q <= rrx_pkg::PH_PROCESS;
            RRX_Q4: phase_out_q <= rrx_pkg::PH_WRITE;
         endcase
      end
   end

   // ************************************************************
   // decode
   // ************************************************************
   assign hit = instr_valid && is_rot_right_plain(instr_word); // RL1

   rrx_addr_gen #(
      .ADDR_W(ADDR_W),
      .BSR_W(BSR_W)
   ) u_addr (
      .faddr(instr_word[rrx_pkg::FADDR_MSB:rrx_pkg::FADDR_LSB]),
      .acc_sel(instr_word[rrx_pkg::ACC_BIT]),
      .ext_set_en(ext_set_en),
      .bank_select_reg(bank_select_reg),
      .index_base(index_base),
      .data_addr(op_addr),
      .indexed(op_indexed)
   );

   // instruction is taken only in the decode phase
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         busy_q <= 1'b0;
         dest_q <= rrx_pkg::DEST_FILE;
         op_hit <= 1'b0;
         mem_addr <= '0;
         idx_mode <= 1'b0;
      end else if (phase_q == RRX_Q1) begin
         busy_q <= hit; // RL1
         op_hit <= hit;
         if (hit) begin
            dest_q <= instr_word[rrx_pkg::DEST_BIT];
            mem_addr <= op_addr; // RL5 RL6 RL7
            idx_mode <= op_indexed;
         end
      end else if (phase_q == RRX_Q4) begin
         busy_q <= 1'b0;
         op_hit <= 1'b0;
      end else begin
         op_hit <= 1'b0;
      end
   end

   // ************************************************************
   // read phase
   // ************************************************************
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         mem_rd_en <= 1'b0;
      end else begin
         mem_rd_en <= (phase_q == RRX_Q1) && hit; // RL9
      end
   end

   // ************************************************************
   // process and write phases
   // ************************************************************
   assign result = rot_right(mem_rdata); // RL2

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         mem_wr_en <= 1'b0;
         wreg_wr_en <= 1'b0;
      end else if (phase_q == RRX_Q3 && busy_q) begin
         mem_wr_en <= (dest_q == rrx_pkg::DEST_FILE); // RL4
         wreg_wr_en <= (dest_q == rrx_pkg::DEST_WREG); // RL3
      end else begin
         mem_wr_en <= 1'b0;
         wreg_wr_en <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         mem_wdata <= rrx_pkg::DATA_RST;
         wreg_wdata <= rrx_pkg::DATA_RST;
      end else if (phase_q == RRX_Q3 && busy_q) begin
         mem_wdata <= result; // RL2
         wreg_wdata <= result;
      end
   end

   // only negative and zero are offered; carry has no port here
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         flag_wr_en <= 1'b0;
         flag_n <= 1'b0;
         flag_z <= 1'b0;
      end else if (phase_q == RRX_Q3 && busy_q) begin
         flag_wr_en <= 1'b1; // RL8
         flag_n <= result[7]; // RL8
         flag_z <= (result == 8'h00); // RL8
      end else begin
         flag_wr_en <= 1'b0;
      end
   end

   assign phase = phase_out_q;
endmodule

// *** rrx_rot_checker.sv ***
// assertion checker for the rotate-right execution block
`timescale 1ns/100ps
module rrx_rot_checker #(
   parameter int ADDR_W = 12,
   parameter int BSR_W = 4
) (
   input wire logic ref_clk, // clock
   input wire logic resetn, // reset
   input wire logic instr_valid, // valid
   input wire logic [15:0] instr_word, // word
   input wire logic [BSR_W-1:0] bank_select_reg, // bank
   input wire logic ext_set_en, // ext
   input wire logic [ADDR_W-1:0] index_base, // base
   input wire logic [7:0] mem_rdata, // rdata
   input wire logic [1:0] phase, // phase
   input wire logic op_hit, // taken
   input wire logic [ADDR_W-1:0] mem_addr, // addr
   input wire logic mem_rd_en, // rd
   input wire logic mem_wr_en, // wr
   input wire logic [7:0] mem_wdata, // wdata
   input wire logic wreg_wr_en, // w wr
   input wire logic [7:0] wreg_wdata, // w data
   input wire logic flag_wr_en, // flag wr
   input wire logic flag_n, // n
   input wire logic flag_z, // z
   input wire logic idx_mode // indexed
);
   logic [7:0] f_q, rot_q;
   logic [BSR_W-1:0] bsr_q;
   logic [ADDR_W-1:0] base_q;
   logic acc_q, ext_q, hit, ix;
   assign hit = phase == 2'h0 && instr_valid
      && instr_word[15:10] == rrx_pkg::OPC_ROT_RIGHT_PLAIN;
   assign ix = !acc_q && ext_q && f_q <= 8'h5f;
   // *****
   // operand capture
   // *****
   always_ff @(posedge ref_clk) begin
      if (hit) begin
         f_q <= instr_word[7:0];
         acc_q <= instr_word[8];
         bsr_q <= bank_select_reg;
         ext_q <= ext_set_en;
         base_q <= index_base;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (phase == 2'h2) begin
         rot_q <= {mem_rdata[0], mem_rdata[7:1]};
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence s_exec;
      ##1 op_hit && mem_rd_en ##2 flag_wr_en;
   endsequence
   AST_DECODE: assert property (hit |-> s_exec)
      else $error("rotate not executed");
   AST_IGNORE: assert property (phase == 2'h0 && !hit |=> !op_hit)
      else $error("foreign word taken");
   AST_ROTATE: assert property (op_hit
      |-> ##2 mem_wdata == rot_q && wreg_wdata == rot_q)
      else $error("bad rotation");
   AST_DEST_W: assert property (hit && !instr_word[9]
      |-> ##3 wreg_wr_en && !mem_wr_en) else $error("w dest");
   AST_DEST_F: assert property (hit && instr_word[9]
      |-> ##3 mem_wr_en && !wreg_wr_en) else $error("file dest");
   AST_SHARED: assert property (op_hit && !acc_q && !ix |-> !idx_mode
      && mem_addr == {(f_q >= (ext_q ? 8'h60 : 8'h80)) ? 4'hf : 4'h0, f_q})
      else $error("shared address");
   AST_BANKED: assert property (op_hit && acc_q
      |-> !idx_mode && mem_addr == {bsr_q, f_q}) else $error("banked");
   AST_INDEX: assert property (op_hit && ix
      |-> idx_mode && mem_addr == base_q + f_q) else $error("indexed");
   AST_FLAGS: assert property (flag_wr_en
      |-> flag_n == rot_q[7] && flag_z == (rot_q == 8'h00))
      else $error("flags");
endmodule
bind rrx_rot_exec rrx_rot_checker #(.ADDR_W(ADDR_W), .BSR_W(BSR_W)) u_chk (
   .ref_clk, .resetn, .instr_valid, .instr_word, .bank_select_reg,
   .ext_set_en, .index_base, .mem_rdata, .phase, .op_hit, .mem_addr,
   .mem_rd_en, .mem_wr_en, .mem_wdata, .wreg_wr_en, .wreg_wdata,
   .flag_wr_en, .flag_n, .flag_z, .idx_mode);

// *** test_rrx_rot_exec.sv ***
// self-checking testbench for the rotate-right execution block
`timescale 1ns/100ps
module test_rrx_rot_exec;
   logic ref_clk = 1'b0, resetn = 1'b0, instr_valid = 1'b0, ext_set_en = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic [3:0] bank_select_reg = 4'h0;
   logic [11:0] index_base = 12'h000, mem_addr;
   logic [7:0] mem_rdata = 8'h00, mem_wdata, wreg_wdata;
   logic [1:0] phase;
   logic op_hit, mem_rd_en, mem_wr_en, wreg_wr_en, flag_wr_en;
   logic flag_n, flag_z, idx_mode;
   int error_cnt = 0;
   int check_count = 0;
   always #4 ref_clk = ~ref_clk;
   rrx_rot_exec dut (.ref_clk, .resetn, .instr_valid, .instr_word,
      .bank_select_reg, .ext_set_en, .index_base, .mem_rdata, .phase,
      .op_hit, .mem_addr, .mem_rd_en, .mem_wr_en, .mem_wdata, .wreg_wr_en,
      .wreg_wdata, .flag_wr_en, .flag_n, .flag_z, .idx_mode);
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // *****
   // one instruction through its four phases
   // *****
   task automatic run(input logic [15:0] w, input logic [3:0] b,
      input logic e, input logic [7:0] rd, input logic [11:0] ea,
      input logic ei);
      logic [7:0] r;
      r = {rd[0], rd[7:1]};
      while (phase !== 2'h0) @(negedge ref_clk);
      instr_valid = 1'b1;
      instr_word = w;
      bank_select_reg = b;
      ext_set_en = e;
      @(negedge ref_clk);
      instr_valid = 1'b0;
      mem_rdata = rd;
      chk({10'h000, op_hit, mem_rd_en}, 12'h003);
      chk({10'h000, phase}, {10'h000, rrx_pkg::PH_READ});
      chk(mem_addr, ea);
      chk({11'h000, idx_mode}, {11'h000, ei});
      repeat (2) @(negedge ref_clk);
      mem_rdata = ~rd;
      chk({10'h000, phase}, {10'h000, rrx_pkg::PH_WRITE});
      chk({9'h000, mem_wr_en, wreg_wr_en, flag_wr_en},
         {9'h000, w[9], ~w[9], 1'b1});
      chk({4'h0, w[9] ? mem_wdata : wreg_wdata}, {4'h0, r});
      chk({10'h000, flag_n, flag_z}, {10'h000, r[7], r == 8'h00});
      @(negedge ref_clk);
   endtask
   task automatic t_banked;
      run(16'h43c5, 4'h3, 1'b0, 8'hd7, 12'h3c5, 1'b0);
      run(16'h4190, 4'ha, 1'b0, 8'h01, 12'ha90, 1'b0);
      $display("test banked done");
   endtask
   task automatic t_shared;
      run(16'h4090, 4'h5, 1'b0, 8'h02, 12'hf90, 1'b0);
      run(16'h427f, 4'h5, 1'b0, 8'hfe, 12'h07f, 1'b0);
      $display("test shared done");
   endtask
   task automatic t_indexed;
      index_base = 12'h123;
      run(16'h425f, 4'h2, 1'b1, 8'h00, 12'h182, 1'b1);
      run(16'h4260, 4'h2, 1'b1, 8'h80, 12'hf60, 1'b0);
      run(16'h435f, 4'h2, 1'b1, 8'h55, 12'h25f, 1'b0);
      $display("test indexed done");
   endtask
   task automatic t_ignored;
      logic seen;
      seen = 1'b0;
      while (phase !== 2'h0) @(negedge ref_clk);
      instr_valid = 1'b1;
      instr_word = 16'h4400;
      repeat (5) begin
         @(negedge ref_clk);
         seen = seen | op_hit | flag_wr_en;
         // right word, but offered outside the decode phase
         instr_word = 16'h43c5;
         instr_valid = phase == 2'h1 || phase == 2'h2;
      end
      instr_valid = 1'b0;
      chk({11'h000, seen}, 12'h000);
      $display("test ignored done");
   endtask
   // *****
   // reset in mid-instruction, then a fresh instruction
   // *****
   task automatic t_reset;
      while (phase !== 2'h0) @(negedge ref_clk);
      instr_valid = 1'b1;
      instr_word = 16'h43c5;
      bank_select_reg = 4'h3;
      ext_set_en = 1'b0;
      @(negedge ref_clk);
      instr_valid = 1'b0;
      resetn = 1'b0;
      @(negedge ref_clk);
      chk({2'h0, phase, op_hit, mem_rd_en, mem_wr_en, wreg_wr_en,
         flag_wr_en, flag_n, flag_z, idx_mode}, 12'h000);
      chk(mem_addr, 12'h000);
      chk({4'h0, mem_wdata}, {4'h0, rrx_pkg::DATA_RST});
      resetn = 1'b1;
      run(16'h4190, 4'h5, 1'b0, 8'h81, 12'h590, 1'b0);
      $display("test reset done");
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(negedge ref_clk);
      resetn = 1'b1;
      t_banked;
      t_shared;
      t_indexed;
      t_ignored;
      t_reset;
      test_done;
   end
   initial begin
      #5000;
      error_cnt++;
      test_done;
   end
endmodule
